/* File: bench/rcg_ir_load.sv */
// Far side model: base timer sources and the infrared driver load on the carrier.
`timescale 1ns/1ps
module rcg_ir_load (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       meas,
  input  wire logic       carrier,
  output logic            tmr0,
  output logic            tmr3,
  output logic [7:0]      hi_cnt,
  output logic [7:0]      rise_cnt,
  output logic [7:0]      min_run
);
  logic [3:0] div0;
  logic [3:0] div3;
  logic [7:0] run;
  logic       prev;

  // Timer outputs hold every phase for 4 and 6 clocks, well above one clock.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div0 <= 4'h0;
      div3 <= 4'h0;
      tmr0 <= 1'b0;
      tmr3 <= 1'b0;
    end else begin
      div0 <= (div0 == 4'h3) ? 4'h0 : div0 + 4'h1;
      div3 <= (div3 == 4'h5) ? 4'h0 : div3 + 4'h1;
      if (div0 == 4'h3) tmr0 <= ~tmr0;
      if (div3 == 4'h5) tmr3 <= ~tmr3;
    end
  end

  // The load counts high samples, rising edges and the shortest whole pulse.
  always_ff @(posedge sys_clk) begin
    prev <= carrier;
    run <= carrier ? run + 8'h01 : 8'h00;
    if (!meas) begin
      hi_cnt <= 8'h00;
      rise_cnt <= 8'h00;
      min_run <= 8'hff;
    end else begin
      hi_cnt <= hi_cnt + {7'h00, carrier};
      if (carrier && !prev) rise_cnt <= rise_cnt + 8'h01;
      if (!carrier && prev && run < min_run) min_run <= run;
    end
  end
endmodule

/* File: bench/tb_remote_carrier_generator.sv */
// Self-checking testbench of the remote carrier generator.
`timescale 1ns/1ps
module tb_remote_carrier_generator
  import rcg_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] awaddr = 16'h0000;
  logic [15:0] araddr = 16'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        io_fn = 1'b0, low_pwr = 1'b0, meas = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        carrier, port_pin, tmr0, tmr3;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [7:0]  hi_cnt, rise_cnt, min_run;
  int          fail_count = 0;
  int          cmp_count = 0;
  logic [7:0]  codes [6] = '{8'h18, 8'h1a, 8'h1c, 8'h1e, 8'h19, 8'h1b};
  logic [7:0]  hi_exp [6] = '{8'h48, 8'h30, 8'h48, 8'h48, 8'h48, 8'h30};
  logic [7:0]  rs_exp [6] = '{8'h12, 8'h0c, 8'h12, 8'h12, 8'h0c, 8'h08};

  // The clock toggles every half period of 10 ns.
  always #10 sys_clk = ~sys_clk;

  rcg_top i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer0_out(tmr0),
    .timer3_out(tmr3), .timer0_io_function(io_fn), .low_power(low_pwr),
    .carrier_output_pin(carrier), .shared_port_pin(port_pin)
  );

  // The load hangs on the shared pin, which software has set up as an output.
  rcg_ir_load i_load (
    .sys_clk(sys_clk), .rst_n(rst_n), .meas(meas), .carrier(port_pin),
    .tmr0(tmr0), .tmr3(tmr3), .hi_cnt(hi_cnt), .rise_cnt(rise_cnt),
    .min_run(min_run)
  );

  // ****************************************************************
  // Bus cycles and comparison
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Offers address and data together and waits for the write answer.
  task automatic bus_write(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic bus_read(input logic [15:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Lets the load count the carrier over a window of w clocks.
  task automatic measure(input int w);
    meas <= 1'b1;
    repeat (w) @(posedge sys_clk);
    #1;
    meas = 1'b0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_and_bus;
    check(carrier, 1'b0);
    check(port_pin, 1'b0);
    bus_read(CTRL_ADDR);
    check(rd, 32'h00000000);
    bus_read(16'h0000);
    check(resp, RESP_DECERR);
    check(rd, 32'h00000000);
    bus_write(STATUS_ADDR, 8'h1f, 4'h1);
    check(resp, RESP_SLVERR);
    bus_write(CTRL_ADDR, 8'he7, 4'h1);
    check(resp, RESP_OKAY);
    bus_write(CTRL_ADDR, 8'h00, 4'h0);
    bus_read(CTRL_ADDR);
    check(rd, 32'h00000027);
    bus_write(CTRL_ADDR, 8'h00, 4'h1);
  endtask

  // Pin follows the timer function until the carrier is routed to it.
  task automatic t_pin;
    io_fn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check(port_pin, 1'b1);
    bus_write(CTRL_ADDR, 8'h10, 4'h1);
    repeat (3) @(posedge sys_clk);
    check(port_pin, 1'b0);
    io_fn <= 1'b0;
  endtask

  // Both bases with half and third duty, raw duty codes on timer 0 only, set in separate accesses from the enable.
  task automatic t_modes;
    for (int i = 0; i < 6; i++) begin
      bus_write(CTRL_ADDR, codes[i] & 8'hf7, 4'h1);
      bus_write(CTRL_ADDR, codes[i], 4'h1);
      repeat (40) @(posedge sys_clk);
      measure(144);
      check(hi_cnt, hi_exp[i]);
      check(rise_cnt, rs_exp[i]);
      bus_write(CTRL_ADDR, codes[i] & 8'hf7, 4'h1);
    end
  endtask

  // Disable lands during a high phase; that pulse must still be whole.
  task automatic t_disable;
    bus_write(CTRL_ADDR, 8'h11, 4'h1);
    bus_write(CTRL_ADDR, 8'h19, 4'h1);
    repeat (40) @(posedge sys_clk);
    meas <= 1'b1;
    do @(posedge sys_clk); while (carrier !== 1'b0);
    do @(posedge sys_clk); while (carrier !== 1'b1);
    bus_write(CTRL_ADDR, 8'h11, 4'h1);
    repeat (20) @(posedge sys_clk);
    #1;
    check(min_run, 8'h06);
    meas = 1'b0;
    @(posedge sys_clk);
    measure(144);
    check(hi_cnt, 8'h00);
  endtask

  task automatic t_low_power;
    bus_write(CTRL_ADDR, 8'h19, 4'h1);
    repeat (40) @(posedge sys_clk);
    low_pwr <= 1'b1;
    repeat (4) @(posedge sys_clk);
    bus_read(STATUS_ADDR);
    check(rd & 32'h00000017, 32'h00000010);
    measure(144);
    check(hi_cnt, 8'h00);
    @(posedge sys_clk);
    low_pwr <= 1'b0;
    repeat (40) @(posedge sys_clk);
    measure(144);
    check(hi_cnt, 8'h48);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence after 12 clocks of reset.
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset_and_bus();
    t_pin();
    t_modes();
    t_disable();
    t_low_power();
    report_and_stop();
  end

  // Watchdog cuts a hang well past the expected run length.
  initial begin
    repeat (6000) @(posedge sys_clk);
    fail_count++;
    report_and_stop();
  end
endmodule

/* File: core/rcg_pkg.sv */
// Shared constants and types of the remote carrier generator.
package rcg_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W        = 16;
  // Byte addresses; the status word sits in the next aligned slot.
  localparam logic [15:0] CTRL_ADDR     = 16'h3f6c;
  localparam logic [15:0] STATUS_ADDR   = 16'h3f70;
  localparam logic [5:0]  CTRL_RESET    = 6'h00;

  // Field positions of the control register.
  localparam int unsigned BIT_BASE_SEL  = 0;
  localparam int unsigned BIT_DUTY_LO   = 1;
  localparam int unsigned BIT_DUTY_HI   = 2;
  localparam int unsigned BIT_OUT_EN    = 3;
  localparam int unsigned BIT_PIN_SEL   = 4;
  localparam int unsigned BIT_RSVD      = 5;

  // Field positions of the status register.
  localparam int unsigned ST_CARRIER    = 0;
  localparam int unsigned ST_GATE       = 1;
  localparam int unsigned ST_WAVE       = 2;
  localparam int unsigned ST_BASE       = 3;
  localparam int unsigned ST_LOW_POWER  = 4;

  // Bus responses.
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    DUTY_HALF  = 2'b00,
    DUTY_THIRD = 2'b01,
    DUTY_RAW_A = 2'b10,
    DUTY_RAW_B = 2'b11
  } rcg_duty_t;

  typedef enum logic [1:0] {
    PH_HIGH = 2'b00,
    PH_LOW1 = 2'b01,
    PH_LOW2 = 2'b10
  } rcg_phase_t;

  typedef enum logic [1:0] {
    SEL_NONE   = 2'b00,
    SEL_CTRL   = 2'b01,
    SEL_STATUS = 2'b10
  } rcg_sel_t;

  typedef struct packed {
    logic      rsvd;
    logic      pin_sel;
    logic      out_en;
    rcg_duty_t duty;
    logic      base_sel;
  } rcg_ctrl_t;

  typedef struct packed {
    logic       base_d;
    logic       wave;
    logic       gate;
    logic       out;
    rcg_phase_t ph;
  } rcg_shaper_st_t;

  typedef struct packed {
    logic        t0_s1;
    logic        t0_s2;
    logic        t3_s1;
    logic        t3_s2;
    rcg_ctrl_t   ctrl;
    logic        aw_held;
    logic [15:0] awaddr;
    logic        w_held;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
    logic        pin;
  } rcg_top_st_t;

endpackage

/* File: core/rcg_shaper.sv */
// Carrier shaping and enable gating on the resampled base timer output.
`timescale 1ns/1ps
module rcg_shaper
  import rcg_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      rst_n,
  input  wire logic      base,
  input  wire rcg_duty_t duty,
  input  wire logic      enable,
  input  wire logic      halt,
  output logic           carrier_out,
  output logic           gate_open,
  output logic           wave_level
);

  rcg_shaper_st_t st;
  rcg_shaper_st_t next_st;
  logic           tick;

  // ****************************************************************
  // Waveform and gate
  // ****************************************************************
  // Every edge of the base output is one base cycle tick.
  always_comb begin
    tick    = (base != st.base_d);
    next_st = st;
    next_st.base_d = base;
    case (duty)
      DUTY_HALF: begin
        if (tick) begin
          next_st.wave = ~st.wave;
        end
      end
      DUTY_THIRD: begin
        if (tick) begin
          case (st.ph)
            PH_HIGH: next_st.ph = PH_LOW1;
            PH_LOW1: next_st.ph = PH_LOW2;
            PH_LOW2: next_st.ph = PH_HIGH;
            default: next_st.ph = PH_HIGH;
          endcase
          next_st.wave = (next_st.ph == PH_HIGH);
        end
      end
      default: begin
        next_st.wave = base;
      end
    endcase
    // Outside third duty the phase tracks the wave, so entering third duty never
    // stretches a high phase that another mode started.
    if (duty != DUTY_THIRD) begin
      next_st.ph = next_st.wave ? PH_HIGH : PH_LOW2;
    end
    // Outside halt the gate only moves while the wave is low, so a disable never cuts a high phase; halt can.
    next_st.gate = st.wave ? st.gate : enable;
    if (halt) begin
      next_st.wave = 1'b0;
      next_st.gate = 1'b0;
      next_st.ph   = PH_LOW2;
    end
    next_st.out = next_st.wave & next_st.gate;
  end

  // State register; all fields clear at reset.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign carrier_out = st.out;
  assign gate_open   = st.gate;
  assign wave_level  = st.wave;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_wave_high_open;
    st.gate && st.wave && !halt;
  endsequence

  AST_HALT_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_n)
    halt |=> !carrier_out && !wave_level)
    else $error("Carrier active after low-power request.");

  AST_HOLD_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_wave_high_open |=> gate_open)
    else $error("Gate closed during a high phase.");

  AST_FALL_WITH_WAVE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(carrier_out) |-> !wave_level)
    else $error("Carrier pulse truncated.");

  AST_OUT_NEEDS_GATE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    carrier_out |-> gate_open && wave_level)
    else $error("Carrier high without open gate.");

  AST_HALF_TOGGLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (duty == DUTY_HALF && tick && !halt) |=> (wave_level != $past(wave_level)))
    else $error("Half duty wave missed a base tick.");

  AST_THIRD_SHORT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (duty == DUTY_THIRD && tick && wave_level) |=> !wave_level)
    else $error("Third duty high phase too long.");

  AST_RAW_FOLLOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (duty[1] && !halt) |=> (wave_level == $past(base)))
    else $error("Raw mode does not follow base output.");

endmodule

/* File: core/rcg_top.sv */
// Remote carrier generator top with its register slave and pin selection.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps

module rcg_top
  import rcg_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        timer0_out,
  input  wire logic        timer3_out,
  input  wire logic        timer0_io_function,
  input  wire logic        low_power,
  output logic             carrier_output_pin,
  output logic             shared_port_pin
);

  rcg_top_st_t st;
  rcg_top_st_t next_st;
  logic        base;
  logic        carrier;
  logic        gate_open;
  logic        wave_level;
  logic        do_write;
  rcg_sel_t    wsel;
  rcg_sel_t    rsel;
  logic [7:0]  status;

  // Maps a byte address to the register it selects.
  function automatic rcg_sel_t decode(input logic [15:0] addr);
    if (addr == CTRL_ADDR) begin
      decode = SEL_CTRL;
    end else if (addr == STATUS_ADDR) begin
      decode = SEL_STATUS;
    end else begin
      decode = SEL_NONE;
    end
  endfunction

  // ****************************************************************
  // Carrier path
  // ****************************************************************
  // Base timer selection reads only the second flop of each synchroniser.
  assign base = st.ctrl.base_sel ? st.t3_s2 : st.t0_s2;

  rcg_shaper u_shaper (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .base        (base),
    .duty        (st.ctrl.duty),
    .enable      (st.ctrl.out_en),
    .halt        (low_power),
    .carrier_out (carrier),
    .gate_open   (gate_open),
    .wave_level  (wave_level)
  );

  // Status byte shows the live carrier state.
  always_comb begin
    status               = 8'h00;
    status[ST_CARRIER]   = carrier;
    status[ST_GATE]      = gate_open;
    status[ST_WAVE]      = wave_level;
    status[ST_BASE]      = base;
    status[ST_LOW_POWER] = low_power;
  end

  // ****************************************************************
  // Register slave
  // ****************************************************************
  // Address and data ready come straight from the hold flags; read address ready comes from the read valid flag.
  assign s_axi_awready = ~st.aw_held;
  assign s_axi_wready  = ~st.w_held;
  assign s_axi_arready = ~st.rvalid;
  assign do_write      = st.aw_held & st.w_held & ~st.bvalid;
  assign wsel          = decode(st.awaddr);
  assign rsel          = decode(s_axi_araddr);

  // Next state of synchronisers, bus channels, control and pin.
  always_comb begin
    next_st       = st;
    next_st.t0_s1 = timer0_out;
    next_st.t0_s2 = st.t0_s1;
    next_st.t3_s1 = timer3_out;
    next_st.t3_s2 = st.t3_s1;
    if (s_axi_awvalid && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.wdata  = s_axi_wdata[7:0];
      next_st.wstrb0 = s_axi_wstrb[0];
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      case (wsel)
        SEL_CTRL: begin
          next_st.bresp = RESP_OKAY;
          if (st.wstrb0) begin
            next_st.ctrl = rcg_ctrl_t'(st.wdata[5:0]);
          end
        end
        SEL_STATUS: next_st.bresp = RESP_SLVERR;
        default:    next_st.bresp = RESP_DECERR;
      endcase
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      case (rsel)
        SEL_CTRL: begin
          next_st.rdata = {2'b00, st.ctrl};
          next_st.rresp = RESP_OKAY;
        end
        SEL_STATUS: begin
          next_st.rdata = status;
          next_st.rresp = RESP_OKAY;
        end
        default: begin
          next_st.rdata = 8'h00;
          next_st.rresp = RESP_DECERR;
        end
      endcase
    end
    next_st.pin = st.ctrl.pin_sel ? carrier : timer0_io_function;
  end

  // State register; control bits clear at reset.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign s_axi_bvalid       = st.bvalid;
  assign s_axi_bresp        = st.bresp;
  assign s_axi_rvalid       = st.rvalid;
  assign s_axi_rresp        = st.rresp;
  assign s_axi_rdata        = {24'h000000, st.rdata};
  assign carrier_output_pin = carrier;
  assign shared_port_pin    = st.pin;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Each sequence keeps the selection steady up to the cycle in which base is checked.
  sequence s_t0_steady_high;
    (!st.ctrl.base_sel && timer0_out) [*3] ##1 !st.ctrl.base_sel;
  endsequence

  sequence s_t3_steady_high;
    (st.ctrl.base_sel && timer3_out) [*3] ##1 st.ctrl.base_sel;
  endsequence

  sequence s_t3_steady_low;
    (st.ctrl.base_sel && !timer3_out) [*3] ##1 st.ctrl.base_sel;
  endsequence

  AST_BASE_TIMER0: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_t0_steady_high |-> base)
    else $error("Timer 0 output not used as base.");

  AST_BASE_TIMER3: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_t3_steady_high |-> base)
    else $error("Timer 3 output not used as base.");

  AST_BASE_TIMER3_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_t3_steady_low |-> !base)
    else $error("Timer 3 low level not used as base.");

  AST_READ_ANSWER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
    else $error("Read address taken without a read answer.");

  AST_PIN_MUX: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st.ctrl.pin_sel |=> (shared_port_pin == $past(carrier)))
    else $error("Shared pin does not carry the carrier.");

  AST_PIN_TIMER: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !st.ctrl.pin_sel |=> (shared_port_pin == $past(timer0_io_function)))
    else $error("Shared pin does not carry the timer function.");

  AST_CTRL_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (do_write && wsel == SEL_CTRL && st.wstrb0)
      |=> (st.ctrl == rcg_ctrl_t'($past(st.wdata[5:0]))) && s_axi_bvalid)
    else $error("Control write not applied.");

endmodule
